// ==== count_source_sel.v ====
// Count source selector: one-cycle tick for full, div-2, div-8 or oscillator rate.
// Assumes the oscillator edge arrives already synchronised.
`include "reload_timer_defs.vh"
`timescale 1ns/1ps
module count_source_sel (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Selection and oscillator edge
	input wire [1:0] sel_i,
	input wire osc_rise_i,
	// Count source tick
	output reg tick_o
);
	reg [2:0] div_q;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			div_q <= `DIV_ZERO;
		end else begin
			div_q <= div_q + `DIV_ONE;
		end
	end

	always @* begin
		case (sel_i)
			`SRC_FULL: begin
				tick_o = 1'b1;
			end
			`SRC_DIV2: begin
				tick_o = div_q[0];
			end
			`SRC_DIV8: begin
				tick_o = (div_q == `DIV_LAST);
			end
			`SRC_OSC: begin
				tick_o = osc_rise_i;
			end
			default: begin
				tick_o = 1'b0;
			end
		endcase
	end
endmodule

// ==== pin_sync.v ====
// Two-stage synchroniser with edge detection after the second stage.
// Assumes an asynchronous level input and the system clock.
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Asynchronous input
	input wire async_i,
	// Synchronised level and edges
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o = sync_q & ~prev_q;
	assign fall_o = ~sync_q & prev_q;
endmodule

// ==== pulse_source.sv ====
// External pulse source on the timer pin.
// Assumes no pull-up; the source itself drives the pin high while it is off.
`timescale 1ns/1ps
module pulse_source #(parameter HALF = 3) (
	// Clock and control
	input wire sys_clk_i,
	input wire run_i,
	// Pin drive
	output reg pin_o
);
integer n = 0;
always @(posedge sys_clk_i) begin
	if (!run_i) begin
		n <= 0;
		pin_o <= 1'b1;
	end else if (n == HALF - 1) begin
		n <= 0;
		pin_o <= ~pin_o;
	end else
		n <= n + 1;
end
endmodule

// ==== reload_timer.v ====
// Eight-bit down-counting reload timer with eight-bit prescaler and five modes.
// Assumes control inputs on the system clock; pin and oscillator are asynchronous.
//
// Operation
// - Two stages, 8-bit prescaler and 8-bit timer, each with reload and counter.
// - One write port per stage reaches reload and counter together while stopped; reload only while counting.
// - Selected count source paces counting and reloading in every mode but event counter; period edges reload directly.
// - Timer mode counts the internal source only, no external measurement.
// - Pulse output mode counts internal source, inverts output on underflow.
// - Pulse output and event modes output equal high/low rectangular wave.
// - Event counter mode counts pulses on the timer input pin.
// - Width mode counts internal source while the external pulse lasts.
// - Period mode counts internal source between successive active edges.
// - Bidirectional pin direction follows mode; second pin is output only.
// - Timer runs alone, sharing no counting state with other timers.
`include "reload_timer_defs.vh"
`timescale 1ns/1ps
module reload_timer (
	// Clock and reset
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Control
	input wire count_start_i,
	input wire force_stop_i,
	input wire [2:0] mode_i,
	input wire [1:0] clk_sel_i,
	input wire source_cut_i,
	input wire pin_polarity_i,
	input wire out_enable_i,
	input wire flag_clr_i,
	// Prescale and count register writes
	input wire pre_wr_i,
	input wire [7:0] pre_wdata_i,
	input wire cnt_wr_i,
	input wire [7:0] cnt_wdata_i,
	// Pins and oscillator
	input wire timer_bidir_pin_i,
	input wire onchip_oscillator_clock_i,
	output reg timer_bidir_pin_o,
	output reg timer_bidir_pin_oe_o,
	output reg timer_output_pin_o,
	// Status and readback
	output reg [7:0] pre_count_o,
	output reg [7:0] cnt_count_o,
	output reg counting_o,
	output reg underflow_flag_o,
	output reg edge_flag_o,
	output reg irq_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [7:0] pre_rld_q;
	reg [7:0] pre_cnt_q;
	reg [7:0] pre_cnt_d;
	reg [7:0] tim_rld_q;
	reg [7:0] tim_cnt_q;
	reg [7:0] tim_cnt_d;
	reg [7:0] cap_q;
	reg counting_q;
	reg tog_q;
	reg step;
	wire pin_lvl;
	wire pin_rise;
	wire pin_fall;
	wire osc_rise;
	wire src_tick;
	wire run;
	wire stepping;
	wire act_edge;
	wire end_edge;
	wire act_lvl;
	wire pre_zero;
	wire tim_zero;
	wire pre_uf;
	wire tim_uf;
	wire period_edge;
	wire width_end;
	wire wave_mode;

	// ----------------------------------------
	// Input synchronisers and count source
	// ----------------------------------------
	pin_sync u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(timer_bidir_pin_i),
		.level_o(pin_lvl),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	pin_sync u_osc_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(onchip_oscillator_clock_i),
		.level_o(),
		.rise_o(osc_rise),
		.fall_o()
	);

	count_source_sel u_src (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.sel_i(clk_sel_i),
		.osc_rise_i(osc_rise),
		.tick_o(src_tick)
	);

	// ----------------------------------------
	// Edge and level qualification
	// ----------------------------------------
	// Pin edges trail the pad by two cycles
	assign act_edge = pin_polarity_i ? pin_fall : pin_rise;
	assign end_edge = pin_polarity_i ? pin_rise : pin_fall;
	assign act_lvl = pin_lvl ^ pin_polarity_i;
	// Force stop blocks stepping in its own cycle, so no late underflow
	assign run = counting_q & ~source_cut_i & ~force_stop_i;
	assign wave_mode = (mode_i == `MODE_PULSE_OUT) | (mode_i == `MODE_EVENT);

	// ----------------------------------------
	// Count step per mode
	// ----------------------------------------
	always @* begin
		case (mode_i)
			`MODE_TIMER: begin
				step = src_tick;
			end
			`MODE_PULSE_OUT: begin
				step = src_tick;
			end
			`MODE_EVENT: begin
				step = act_edge;
			end
			`MODE_WIDTH: begin
				step = src_tick & act_lvl;
			end
			`MODE_PERIOD: begin
				step = src_tick;
			end
			default: begin
				step = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Underflow detection
	// ----------------------------------------
	assign stepping = run & step;
	assign pre_zero = (pre_cnt_q == `CNT_ZERO);
	assign tim_zero = (tim_cnt_q == `CNT_ZERO);
	assign pre_uf = stepping & pre_zero;
	assign tim_uf = pre_uf & tim_zero;
	assign period_edge = run & (mode_i == `MODE_PERIOD) & act_edge;
	assign width_end = run & (mode_i == `MODE_WIDTH) & end_edge;

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			counting_q <= 1'b0;
		end else begin
			counting_q <= count_start_i;
		end
	end

	// ----------------------------------------
	// Reload registers
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			pre_rld_q <= `CNT_RST;
			tim_rld_q <= `CNT_RST;
		end else begin
			if (pre_wr_i) begin
				pre_rld_q <= pre_wdata_i;
			end
			if (cnt_wr_i) begin
				tim_rld_q <= cnt_wdata_i;
			end
		end
	end

	// ----------------------------------------
	// Prescaler counter
	// ----------------------------------------
	// Writes while counting reach only the reload registers
	always @* begin
		pre_cnt_d = pre_cnt_q;
		if (pre_wr_i & ~counting_q) begin
			pre_cnt_d = pre_wdata_i;
		end else if (period_edge) begin
			pre_cnt_d = pre_rld_q;
		end else if (stepping) begin
			if (pre_zero) begin
				pre_cnt_d = pre_rld_q;
			end else begin
				pre_cnt_d = pre_cnt_q - `CNT_ONE;
			end
		end
	end

	// ----------------------------------------
	// Timer counter
	// ----------------------------------------
	always @* begin
		tim_cnt_d = tim_cnt_q;
		if (cnt_wr_i & ~counting_q) begin
			tim_cnt_d = cnt_wdata_i;
		end else if (period_edge) begin
			tim_cnt_d = tim_rld_q;
		end else if (pre_uf) begin
			if (tim_zero) begin
				tim_cnt_d = tim_rld_q;
			end else begin
				tim_cnt_d = tim_cnt_q - `CNT_ONE;
			end
		end
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			pre_cnt_q <= `CNT_RST;
			tim_cnt_q <= `CNT_RST;
		end else begin
			pre_cnt_q <= pre_cnt_d;
			tim_cnt_q <= tim_cnt_d;
		end
	end

	// ----------------------------------------
	// Period capture
	// ----------------------------------------
	// Holds the timer count seen at each active edge
	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			cap_q <= `CNT_RST;
		end else if (period_edge) begin
			cap_q <= tim_cnt_q;
		end
	end

	// ----------------------------------------
	// Output wave
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			tog_q <= 1'b0;
		end else if (tim_uf & wave_mode) begin
			tog_q <= ~tog_q;
		end
	end

	// Polarity also inverts the driven pin level
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			timer_bidir_pin_o <= 1'b0;
			timer_bidir_pin_oe_o <= 1'b0;
			timer_output_pin_o <= 1'b0;
		end else begin
			timer_bidir_pin_o <= tog_q ^ pin_polarity_i;
			timer_bidir_pin_oe_o <= (mode_i == `MODE_PULSE_OUT);
			timer_output_pin_o <= out_enable_i & wave_mode & ~tog_q;
		end
	end

	// ----------------------------------------
	// Flags, interrupt and readback
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (sys_rst_i | force_stop_i) begin
			underflow_flag_o <= 1'b0;
			edge_flag_o <= 1'b0;
		end else begin
			// Set wins over clear
			if (tim_uf) begin
				underflow_flag_o <= 1'b1;
			end else if (flag_clr_i) begin
				underflow_flag_o <= 1'b0;
			end
			if (period_edge | width_end) begin
				edge_flag_o <= 1'b1;
			end else if (flag_clr_i) begin
				edge_flag_o <= 1'b0;
			end
		end
	end

	// One-cycle request per timer underflow
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
			counting_o <= 1'b0;
			pre_count_o <= `CNT_RST;
			cnt_count_o <= `CNT_RST;
		end else begin
			irq_o <= tim_uf;
			counting_o <= counting_q;
			pre_count_o <= pre_cnt_q;
			cnt_count_o <= (mode_i == `MODE_PERIOD) ? cap_q : tim_cnt_q;
		end
	end
endmodule

// ==== reload_timer_chk.sv ====
// Checker for the reload timer: flags, pin drive, interrupt and freeze relations.
// Assumes binding to reload_timer on the system clock with synchronous reset.
`timescale 1ns/1ps
module reload_timer_chk (
	// Clock, reset and control
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire force_stop_i,
	input wire [2:0] mode_i,
	input wire source_cut_i,
	input wire out_enable_i,
	input wire flag_clr_i,
	// Outputs watched
	input wire timer_bidir_pin_oe_o,
	input wire timer_output_pin_o,
	input wire [7:0] pre_count_o,
	input wire [7:0] cnt_count_o,
	input wire underflow_flag_o,
	input wire edge_flag_o,
	input wire irq_o
);
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (sys_rst_i);
a_irq_one_cycle: assert property (irq_o |=> !irq_o || pre_count_o == 8'h00)
	else $error("irq held past one cycle");
a_irq_sets_flag: assert property (irq_o |-> underflow_flag_o)
	else $error("irq without underflow flag");
a_flag_sticky: assert property (underflow_flag_o && !flag_clr_i && !force_stop_i |=>
	underflow_flag_o) else $error("underflow flag lost");
a_flag_clear: assert property (flag_clr_i |=> !underflow_flag_o || irq_o)
	else $error("underflow flag not cleared");
a_edge_sticky: assert property (edge_flag_o && !flag_clr_i && !force_stop_i |=>
	edge_flag_o) else $error("edge flag lost");
a_oe_mode: assert property ($past(mode_i) != 3'h1 |-> !timer_bidir_pin_oe_o)
	else $error("pin driven outside pulse output mode");
a_out_pin_mode: assert property (timer_output_pin_o |-> $past(out_enable_i) &&
	($past(mode_i) == 3'h1 || $past(mode_i) == 3'h2)) else $error("output pin wrong mode");
a_stop_resets: assert property (force_stop_i |=> ##1 pre_count_o == 8'hFF &&
	cnt_count_o == 8'hFF) else $error("force stop left counters");
a_cut_freezes: assert property (source_cut_i [*3] |-> $stable(pre_count_o))
	else $error("prescaler moved while cut");
cover property (irq_o);
cover property ($rose(edge_flag_o));
cover property (timer_bidir_pin_oe_o && irq_o);
endmodule

bind reload_timer reload_timer_chk reload_timer_chk_i (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .force_stop_i(force_stop_i),
	.mode_i(mode_i), .source_cut_i(source_cut_i), .out_enable_i(out_enable_i),
	.flag_clr_i(flag_clr_i), .timer_bidir_pin_oe_o(timer_bidir_pin_oe_o),
	.timer_output_pin_o(timer_output_pin_o), .pre_count_o(pre_count_o),
	.cnt_count_o(cnt_count_o), .underflow_flag_o(underflow_flag_o),
	.edge_flag_o(edge_flag_o), .irq_o(irq_o));

// ==== reload_timer_defs.vh ====
// Constants for the eight-bit reload timer: modes, count sources, reset values.
// Assumes inclusion by bare name from the design files of the same folder.
`ifndef RELOAD_TIMER_DEFS_VH
`define RELOAD_TIMER_DEFS_VH

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_TIMER 3'h0
`define MODE_PULSE_OUT 3'h1
`define MODE_EVENT 3'h2
`define MODE_WIDTH 3'h3
`define MODE_PERIOD 3'h4

// ----------------------------------------
// Count source selection
// ----------------------------------------
`define SRC_FULL 2'h0
`define SRC_DIV8 2'h1
`define SRC_OSC 2'h2
`define SRC_DIV2 2'h3
`define DIV_LAST 3'h7
`define DIV_ONE 3'h1
`define DIV_ZERO 3'h0

// ----------------------------------------
// Reset values and counter constants
// ----------------------------------------
`define CNT_RST 8'hFF
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

`endif

// ==== test_eight_bit_reload_timer.sv ====
// Testbench for the reload timer: all modes and count sources, intervals scored.
// Assumes pulse_source on the pin and a 40 ns oscillator, 8 system cycles a tick.
`timescale 1ns/1ps
module test_eight_bit_reload_timer;
reg sys_clk_i = 1'b0;
reg sys_rst_i = 1'b1;
reg start = 1'b0, stop = 1'b0, cut = 1'b0, clr = 1'b0, wr = 1'b0, osc = 1'b0, run_src = 1'b0;
reg [2:0] mode = 3'h0;
reg [1:0] sel = 2'h0;
reg [7:0] pre_d = 8'h00, tim_d = 8'h00;
wire src_pin, pin_o, pin_oe, out_pin, cnting, uflag, eflag, irq;
wire [7:0] pre_cnt, cnt_cnt;
wire pin_wire = pin_oe ? pin_o : src_pin;
integer n_mismatch = 0, samples_checked = 0, seed = 32'hda5f11a1;
integer cyc = 0, last = -1, n_irq = 0, pre, tim;
integer exp_q[$];
always #2.5 sys_clk_i = ~sys_clk_i;
initial begin
	#1.3;
	forever #20 osc = ~osc;
end
reload_timer reload_timer_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.count_start_i(start), .force_stop_i(stop), .mode_i(mode), .clk_sel_i(sel),
	.source_cut_i(cut), .pin_polarity_i(1'b0), .out_enable_i(1'b1), .flag_clr_i(clr),
	.pre_wr_i(wr), .pre_wdata_i(pre_d), .cnt_wr_i(wr), .cnt_wdata_i(tim_d),
	.timer_bidir_pin_i(pin_wire), .onchip_oscillator_clock_i(osc),
	.timer_bidir_pin_o(pin_o), .timer_bidir_pin_oe_o(pin_oe), .timer_output_pin_o(out_pin),
	.pre_count_o(pre_cnt), .cnt_count_o(cnt_cnt), .counting_o(cnting),
	.underflow_flag_o(uflag), .edge_flag_o(eflag), .irq_o(irq));
pulse_source pulse_source_i (.sys_clk_i(sys_clk_i), .run_i(run_src), .pin_o(src_pin));
task stop_test;
	begin
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
task chk(input [7:0] got, input [7:0] want);
	begin
		samples_checked = samples_checked + 1;
		if (got !== want) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	end
endtask
// Scores irq spacing against the oldest expected interval
always @(posedge sys_clk_i) begin : mon
	integer e;
	cyc = cyc + 1;
	if (irq === 1'b1) begin
		n_irq = n_irq + 1;
		if (last >= 0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			samples_checked = samples_checked + 1;
			if (cyc - last != e) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: irq gap %0d want %0d", $time, cyc - last, e);
			end
		end
		last = cyc;
	end
end
task run(input [2:0] m, input [1:0] s, input integer unit);
	integer i, k, n0;
	begin
		pre = $random(seed) & 3;
		tim = $random(seed) & 3;
		@(posedge sys_clk_i);
		mode <= m;
		sel <= s;
		wr <= 1'b1;
		pre_d <= pre[7:0];
		tim_d <= tim[7:0];
		@(posedge sys_clk_i);
		wr <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(pre_cnt, pre[7:0]);
		if (m != 3'h4)
			chk(cnt_cnt, tim[7:0]);
		last = -1;
		n0 = n_irq;
		@(posedge sys_clk_i);
		run_src <= 1'b1;
		start <= 1'b1;
		if (m < 3'h3) begin
			for (i = 0; i < 3; i = i + 1)
				exp_q.push_back(unit * (pre + 1) * (tim + 1));
			k = n0 + 4;
			for (i = 0; i < 3000 && n_irq < k; i = i + 1)
				@(posedge sys_clk_i);
			#1;
			chk(8'(n_irq >= k), 8'h01);
			chk(8'(uflag), 8'h01);
		end else
			repeat (200) @(posedge sys_clk_i);
		#1;
		chk(8'(eflag), 8'(m >= 3'h3));
		chk(8'(pin_oe), 8'(m == 3'h1));
		chk(8'(cnting), 8'h01);
		// Five steps between active edges six cycles apart
		if (m == 3'h4)
			chk(cnt_cnt, 8'(tim - (5 / (pre + 1)) % (tim + 1)));
		@(posedge sys_clk_i);
		cut <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		chk(8'(uflag), 8'h00);
		chk(8'(eflag), 8'h00);
		chk(8'(pin_o), 8'((m == 3'h1 || m == 3'h2) && (n_irq - n0) % 2 == 1));
		chk(8'(out_pin), 8'((m == 3'h1 || m == 3'h2) && (n_irq - n0) % 2 == 0));
		@(posedge sys_clk_i);
		cut <= 1'b0;
		start <= 1'b0;
		run_src <= 1'b0;
		stop <= 1'b1;
		clr <= 1'b1;
		@(posedge sys_clk_i);
		stop <= 1'b0;
		clr <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(8'(cnting), 8'h00);
		exp_q.delete();
	end
endtask
initial begin
	repeat (6) @(posedge sys_clk_i);
	sys_rst_i <= 1'b0;
	run(3'h0, 2'h0, 1);
	run(3'h0, 2'h3, 2);
	run(3'h0, 2'h1, 8);
	run(3'h0, 2'h2, 8);
	run(3'h1, 2'h0, 1);
	run(3'h2, 2'h0, 6);
	run(3'h3, 2'h0, 0);
	run(3'h4, 2'h0, 0);
	stop_test;
end
initial begin
	#100000;
	n_mismatch = n_mismatch + 1;
	stop_test;
end
endmodule
